/* File: design/branch_call_clear_pkg.sv */
// Constants, encodings and state types for the branch, call and clear-file decoder.
package branch_call_clear_pkg;

  localparam int WORD_W = 16;
  localparam int PC_W = 21;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int DADDR_W = 12;
  localparam int TARGET_W = 20;

  // Opcode fields, upper bits of the first instruction word; the call prefix is in the second word
  localparam logic [7:0] OVF_BRANCH_OPCODE = 8'he4;
  localparam logic [7:0] ZERO_BRANCH_OPCODE = 8'he0;
  localparam logic [6:0] CALL_OPCODE = 7'h76;
  localparam logic [3:0] CALL_WORD2_PREFIX = 4'hf;
  localparam logic [6:0] CLEAR_FILE_OPCODE = 7'h35;

  // Field positions and widths within the first and second words
  localparam int OPC8_LSB = 8;
  localparam int OPC7_LSB = 9;
  localparam int FLAG_BIT = 8;
  localparam int PREFIX_LSB = 12;
  localparam int LIT_W = 8;
  localparam int HI_LIT_W = 12;

  // Program counter arithmetic
  localparam logic [PC_W-1:0] BRANCH_BIAS = 21'h000002;
  localparam logic [PC_W-1:0] RETURN_STEP = 21'h000004;

  // Data memory addressing
  localparam logic [DATA_W-1:0] CLEAR_VALUE = 8'h00;
  localparam logic [DATA_W-1:0] INDEXED_LIMIT = 8'h5f;
  localparam logic [DATA_W-1:0] ACCESS_SPLIT = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;

  // Reset values
  localparam logic [WORD_W-1:0] IR_RESET = 16'h0000;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [DATA_W-1:0] SHADOW_RESET = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;
  localparam logic [DADDR_W-1:0] DADDR_RESET = 12'h000;

  // Quarter phases, Gray coded
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } phase_t;

  // Instruction cycle kind
  typedef enum logic {
    ST_EXEC = 1'b0,
    ST_NOP = 1'b1
  } cycle_t;

endpackage

/* File: design/quarter_phase_gen.sv */
// Divides the core clock into four quarter phases per instruction cycle.
`timescale 1ns/1ps
module quarter_phase_gen
  import branch_call_clear_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Phase
  output phase_t phase
);

  typedef struct packed {
    phase_t ph;
  } qstate_t;

  qstate_t s_q;
  qstate_t s_d;

  always_comb begin
    s_d = s_q;
    unique case (s_q.ph)
      PH_Q1: s_d.ph = PH_Q2;
      PH_Q2: s_d.ph = PH_Q3;
      PH_Q3: s_d.ph = PH_Q4;
      PH_Q4: s_d.ph = PH_Q1;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q <= '{ph: PH_Q1};
    end else begin
      s_q <= s_d;
    end
  end

  assign phase = s_q.ph;

endmodule

/* File: design/branch_call_clear_exec.sv */
// Decode and execution of branch on overflow/zero, absolute call and clear-file.
// Notes on behaviour
// RULE1: Branch-on-overflow is one word, fixed upper byte, signed 8-bit offset below.
// RULE2: Overflow set: program counter becomes PC plus 2 plus twice signed offset.
// RULE3: Branch-on-zero is one word; zero set branches to PC plus 2 plus 2n.
// RULE4: Untaken branch takes one cycle; taken takes two, second cycle idle.
// RULE5: Branch phases: decode, read offset, process, then PC write or idle.
// RULE6: Call is two words: opcode, save bit, target low; prefix, target high.
// RULE7: Call pushes the address after the call, PC plus 4, onto return stack.
// RULE8: Save bit set copies working, flags, bank select into shadows; else unchanged.
// RULE9: The 20-bit call target loads program counter bits 20 down to 1.
// RULE10: Call takes two cycles: push in third quarter, PC write in fourth.
// RULE11: Clear-file writes zero into the addressed register and sets the zero flag.
// RULE12: Clear-file is one word: 7-bit opcode, bank bit, 8-bit address, one cycle.
// RULE13: Clear-file with bank bit 0 selects the access bank.
// RULE14: Clear-file with bank bit 1 uses the bank select register.
// RULE15: Extended set, bank bit 0, address up to 95: indexed literal offset.
// RULE16: Branches and calls leave every arithmetic status flag unchanged.
// RULE17: Clear-file reads in second quarter, processes third, writes in fourth.
`timescale 1ns/1ps
module branch_call_clear_exec
  import branch_call_clear_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Program memory and program counter
  input wire logic [WORD_W-1:0] prog_word,
  input wire logic [PC_W-1:0] pc_in,
  output logic pc_wr,
  output logic [PC_W-1:0] pc_wr_data,
  // Return stack
  output logic stack_push,
  output logic [PC_W-1:0] return_stack_top,
  // Core registers and flags
  input wire logic overflow_flag,
  input wire logic zero_flag,
  input wire logic [DATA_W-1:0] working_reg,
  input wire logic [DATA_W-1:0] flags_reg,
  input wire logic [BANK_W-1:0] bank_select_reg,
  input wire logic ext_set_en,
  input wire logic [DADDR_W-1:0] index_base,
  output logic zero_set,
  // Shadow copies
  output logic [DATA_W-1:0] working_shadow,
  output logic [DATA_W-1:0] flags_shadow,
  output logic [BANK_W-1:0] bank_select_shadow,
  // Data memory
  output logic dmem_rd,
  output logic dmem_wr,
  output logic [DADDR_W-1:0] dmem_addr,
  output logic [DATA_W-1:0] dmem_wr_data,
  output logic indexed_mode,
  // Cycle status
  output phase_t phase,
  output logic idle_cycle
);

  typedef struct packed {
    cycle_t st;
    logic [WORD_W-1:0] ir;
    logic [PC_W-1:0] pc_base;
    logic taken;
    logic pc_wr;
    logic [PC_W-1:0] pc_val;
    logic push;
    logic [PC_W-1:0] push_val;
    logic [DATA_W-1:0] wreg_copy;
    logic [DATA_W-1:0] fs;
    logic [BANK_W-1:0] bs;
    logic zset;
    logic drd;
    logic dwr;
    logic [DADDR_W-1:0] daddr;
    logic idx;
  } exec_state_t;

  exec_state_t s_q;
  exec_state_t s_d;

  quarter_phase_gen u_phase (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .phase(phase)
  );

  logic live;
  logic is_ovf_branch;
  logic is_zero_branch;
  logic is_call;
  logic is_clear_file;
  logic [PC_W-1:0] branch_dest;
  logic [PC_W-1:0] call_dest;
  logic [DATA_W-1:0] file_addr;

  // Decoding is gated off in the idle second cycle of a two-cycle instruction
  assign live = (s_q.st == ST_EXEC);
  assign is_ovf_branch = live && (s_q.ir[WORD_W-1:OPC8_LSB] == OVF_BRANCH_OPCODE); // [RULE1]
  assign is_zero_branch = live && (s_q.ir[WORD_W-1:OPC8_LSB] == ZERO_BRANCH_OPCODE); // [RULE3]
  assign is_call = live && (s_q.ir[WORD_W-1:OPC7_LSB] == CALL_OPCODE); // [RULE6]
  assign is_clear_file = live && (s_q.ir[WORD_W-1:OPC7_LSB] == CLEAR_FILE_OPCODE); // [RULE12]
  assign file_addr = s_q.ir[LIT_W-1:0];

  // Signed offset doubled and sign extended to the counter width
  assign branch_dest = s_q.pc_base + BRANCH_BIAS +
    {{(PC_W-LIT_W-1){s_q.ir[LIT_W-1]}}, s_q.ir[LIT_W-1:0], 1'b0}; // [RULE2] [RULE3]

  // Second word is on prog_word in the third quarter; its prefix is not checked
  assign call_dest = {prog_word[HI_LIT_W-1:0], s_q.ir[LIT_W-1:0], 1'b0}; // [RULE6] [RULE9]

  always_comb begin
    s_d = s_q;
    s_d.pc_wr = 1'b0;
    s_d.push = 1'b0;
    s_d.zset = 1'b0;
    s_d.drd = 1'b0;
    s_d.dwr = 1'b0;
    unique case (phase)
      PH_Q1: begin
        // Decode; the address is formed here so the read in Q2 can use it
        s_d.pc_base = pc_in;
        s_d.taken = 1'b0;
        if (is_clear_file) begin
          s_d.drd = 1'b1; // [RULE17]
          if (!s_q.ir[FLAG_BIT] && ext_set_en && (file_addr <= INDEXED_LIMIT)) begin
            s_d.idx = 1'b1;
            s_d.daddr = index_base + {{(DADDR_W-DATA_W){1'b0}}, file_addr}; // [RULE15]
          end else if (!s_q.ir[FLAG_BIT]) begin
            s_d.idx = 1'b0;
            s_d.daddr = (file_addr < ACCESS_SPLIT) ? {ACCESS_LOW_BANK, file_addr} :
              {ACCESS_HIGH_BANK, file_addr}; // [RULE13]
          end else begin
            s_d.idx = 1'b0;
            s_d.daddr = {bank_select_reg, file_addr}; // [RULE14]
          end
        end
      end
      PH_Q2: begin
        // Offset literal is read; the condition is sampled for processing
        if ((is_ovf_branch && overflow_flag) || (is_zero_branch && zero_flag)) begin
          s_d.taken = 1'b1; // [RULE2] [RULE3]
        end
        if (is_call) begin
          s_d.taken = 1'b1;
          s_d.push = 1'b1; // [RULE10]
          s_d.push_val = s_q.pc_base + RETURN_STEP; // [RULE7]
          if (s_q.ir[FLAG_BIT]) begin
            s_d.wreg_copy = working_reg; // [RULE8]
            s_d.fs = flags_reg; // [RULE8]
            s_d.bs = bank_select_reg; // [RULE8]
          end
        end
      end
      PH_Q3: begin
        if (is_call) begin
          s_d.pc_wr = 1'b1; // [RULE10]
          s_d.pc_val = call_dest; // [RULE9]
        end else if ((is_ovf_branch || is_zero_branch) && s_q.taken) begin
          s_d.pc_wr = 1'b1; // [RULE5]
          s_d.pc_val = branch_dest;
        end
        if (is_clear_file) begin
          s_d.dwr = 1'b1; // [RULE17]
          s_d.zset = 1'b1; // [RULE11]
        end
      end
      PH_Q4: begin
        // Next word is latched; a taken branch or a call idles one whole cycle
        s_d.ir = prog_word;
        s_d.st = (live && s_q.taken) ? ST_NOP : ST_EXEC; // [RULE4] [RULE10]
        s_d.idx = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q <= '{st: ST_EXEC, ir: IR_RESET, pc_base: PC_RESET, taken: 1'b0,
        pc_wr: 1'b0, pc_val: PC_RESET, push: 1'b0, push_val: PC_RESET,
        wreg_copy: SHADOW_RESET, fs: SHADOW_RESET, bs: BANK_RESET, zset: 1'b0,
        drd: 1'b0, dwr: 1'b0, daddr: DADDR_RESET, idx: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign pc_wr = s_q.pc_wr;
  assign pc_wr_data = s_q.pc_val;
  assign stack_push = s_q.push;
  assign return_stack_top = s_q.push_val;
  // Only clear-file touches a flag; branches and calls drive no flag write
  assign zero_set = s_q.zset; // [RULE16]
  assign working_shadow = s_q.wreg_copy;
  assign flags_shadow = s_q.fs;
  assign bank_select_shadow = s_q.bs;
  assign dmem_rd = s_q.drd;
  assign dmem_wr = s_q.dwr;
  assign dmem_addr = s_q.daddr;
  assign dmem_wr_data = CLEAR_VALUE; // [RULE11]
  assign indexed_mode = s_q.idx;
  assign idle_cycle = (s_q.st == ST_NOP);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_call_steps;
    stack_push ##1 (pc_wr && !stack_push) ##1 (phase == PH_Q1 && idle_cycle);
  endsequence

  sequence s_idle_cycle;
    (idle_cycle && !pc_wr && !stack_push && !dmem_wr && !zero_set) [*4];
  endsequence

  property p_push_q3;
    stack_push |-> phase == PH_Q3;
  endproperty
  a_push_q3: assert property (p_push_q3) else $error("push outside third quarter"); // [RULE10]

  property p_pc_wr_q4;
    pc_wr |-> phase == PH_Q4;
  endproperty
  a_pc_wr_q4: assert property (p_pc_wr_q4) else $error("pc write outside fourth quarter"); // [RULE5]

  property p_call_two_cycles;
    stack_push |-> s_call_steps ##0 s_idle_cycle;
  endproperty
  a_call_two_cycles: assert property (p_call_two_cycles) else $error("call sequence broken"); // [RULE10]

  property p_push_value;
    stack_push |-> return_stack_top == $past(pc_in, 2) + RETURN_STEP;
  endproperty
  a_push_value: assert property (p_push_value) else $error("wrong return address"); // [RULE7]

  property p_call_target;
    (phase == PH_Q3 && is_call) |=> pc_wr && !pc_wr_data[0] &&
      pc_wr_data == {$past(prog_word[HI_LIT_W-1:0]), $past(prog_word[LIT_W-1:0], 4), 1'b0};
  endproperty
  a_call_target: assert property (p_call_target) else $error("wrong call target"); // [RULE9]

  property p_branch_taken;
    (phase == PH_Q3 && (is_ovf_branch || is_zero_branch) && s_q.taken) |=>
      pc_wr && pc_wr_data == $past(pc_in, 3) + BRANCH_BIAS +
      {{(PC_W-LIT_W-1){$past(prog_word[LIT_W-1], 4)}}, $past(prog_word[LIT_W-1:0], 4), 1'b0}
      ##1 s_idle_cycle;
  endproperty
  a_branch_taken: assert property (p_branch_taken) else $error("taken branch wrong"); // [RULE2]

  property p_branch_untaken;
    (phase == PH_Q2 && is_ovf_branch && !overflow_flag) |=> ##1 !pc_wr ##1 !idle_cycle;
  endproperty
  a_branch_untaken: assert property (p_branch_untaken) else $error("untaken branch wrote"); // [RULE4]

  property p_clear_write;
    dmem_wr |-> phase == PH_Q4 && zero_set && dmem_wr_data == CLEAR_VALUE && $past(dmem_rd, 2);
  endproperty
  a_clear_write: assert property (p_clear_write) else $error("clear write misplaced"); // [RULE17]

  property p_bank_select;
    (phase == PH_Q1 && is_clear_file && s_q.ir[FLAG_BIT]) |=>
      dmem_addr == {$past(bank_select_reg), $past(file_addr)} && !indexed_mode;
  endproperty
  a_bank_select: assert property (p_bank_select) else $error("bank select not used"); // [RULE14]

  property p_shadow_hold;
    (stack_push && !s_q.ir[FLAG_BIT]) |-> $stable(working_shadow) && $stable(flags_shadow) &&
      $stable(bank_select_shadow);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("shadow changed"); // [RULE8]

  property p_shadow_copy;
    (phase == PH_Q2 && is_call && s_q.ir[FLAG_BIT]) |=> working_shadow == $past(working_reg);
  endproperty
  a_shadow_copy: assert property (p_shadow_copy) else $error("shadow not copied"); // [RULE8]

  property p_no_flag_on_branch;
    (pc_wr || stack_push) |-> !zero_set;
  endproperty
  a_no_flag_on_branch: assert property (p_no_flag_on_branch) else $error("flag touched"); // [RULE16]

  property p_shadow_more;
    (phase == PH_Q2 && is_call && s_q.ir[FLAG_BIT]) |=>
      flags_shadow == $past(flags_reg) && bank_select_shadow == $past(bank_select_reg);
  endproperty
  a_shadow_more: assert property (p_shadow_more) else $error("shadows stale"); // [RULE8]

  property p_zero_untaken;
    (phase == PH_Q2 && is_zero_branch && !zero_flag) |=> ##1 !pc_wr ##1 !idle_cycle;
  endproperty
  a_zero_untaken: assert property (p_zero_untaken) else $error("branch idled"); // [RULE4]

  // Indexed window only at or below the limit, and only with the extended set on
  property p_indexed_addr;
    (phase == PH_Q1 && is_clear_file && !s_q.ir[FLAG_BIT] && ext_set_en &&
      file_addr <= INDEXED_LIMIT) |=> indexed_mode &&
      dmem_addr == $past(index_base) + {{(DADDR_W-DATA_W){1'b0}}, $past(file_addr)};
  endproperty
  a_indexed_addr: assert property (p_indexed_addr) else $error("bad index addr"); // [RULE15]

  property p_access_bank;
    (phase == PH_Q1 && is_clear_file && !s_q.ir[FLAG_BIT] &&
      !(ext_set_en && file_addr <= INDEXED_LIMIT)) |=> !indexed_mode &&
      dmem_addr == {($past(file_addr[DATA_W-1]) ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK),
      $past(file_addr)};
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("bad access bank"); // [RULE13]

  property p_clear_zero;
    (phase == PH_Q3 && is_clear_file) |=> dmem_wr && zero_set && !pc_wr && !stack_push;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear missed"); // [RULE11]

endmodule

/* File: verif/mem_stack_model.sv */
// Behavioural data memory and return stack beside the decoder.
`timescale 1ns/1ps
module mem_stack_model
  import branch_call_clear_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Data memory write port
  input wire logic dmem_wr,
  input wire logic [DADDR_W-1:0] dmem_addr,
  input wire logic [DATA_W-1:0] dmem_wr_data,
  // Return stack push port
  input wire logic stack_push,
  input wire logic [PC_W-1:0] return_stack_top
);
  logic [DATA_W-1:0] mem [0:4095];
  logic [PC_W-1:0] stk [0:30];
  int sp = 0;
  // Nonzero preset so a missed clear cannot pass
  initial begin
    foreach (mem[i]) mem[i] = 8'ha5;
  end
  always @(posedge core_clk) begin
    if (dmem_wr === 1'b1) begin
      mem[dmem_addr] <= dmem_wr_data;
    end
    if (stack_push === 1'b1) begin
      stk[sp] <= return_stack_top;
      sp <= (sp + 1) % 31;
    end
  end
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the branch, call and clear-file decoder.
`timescale 1ns/1ps
module tb;
  import branch_call_clear_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [WORD_W-1:0] prog_word = 16'hffff;
  logic [PC_W-1:0] pc_in = 21'h000000;
  logic overflow_flag = 1'b0;
  logic zero_flag = 1'b0;
  logic [DATA_W-1:0] working_reg = 8'h3c;
  logic [DATA_W-1:0] flags_reg = 8'h1f;
  logic [BANK_W-1:0] bank_select_reg = 4'h5;
  logic ext_set_en = 1'b0;
  logic [DADDR_W-1:0] index_base = 12'h300;
  logic pc_wr, stack_push, zero_set, dmem_rd, dmem_wr, indexed_mode, idle_cycle;
  logic [PC_W-1:0] pc_wr_data, return_stack_top, g_pc, g_ret;
  logic [DATA_W-1:0] working_shadow, flags_shadow, dmem_wr_data;
  logic [BANK_W-1:0] bank_select_shadow;
  logic [DADDR_W-1:0] dmem_addr, g_addr, g_raddr;
  phase_t phase;
  int mismatches = 0;
  int comparisons = 0;
  int n_wr, n_push, n_rd, n_dw, n_zs, n_idle, n_idx;

  always #5 core_clk = ~core_clk;

  branch_call_clear_exec DUT (.core_clk, .sys_rst, .prog_word, .pc_in, .pc_wr, .pc_wr_data,
    .stack_push, .return_stack_top, .overflow_flag, .zero_flag, .working_reg, .flags_reg,
    .bank_select_reg, .ext_set_en, .index_base, .zero_set, .working_shadow, .flags_shadow,
    .bank_select_shadow, .dmem_rd, .dmem_wr, .dmem_addr, .dmem_wr_data, .indexed_mode,
    .phase, .idle_cycle);

  mem_stack_model dm (.core_clk, .dmem_wr, .dmem_addr, .dmem_wr_data, .stack_push,
    .return_stack_top);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Word is presented in Q4, word 2 from the next Q1; records two cycles
  task automatic run(input logic [WORD_W-1:0] w, w2, input logic [PC_W-1:0] pc,
      input logic ov, zf);
    do @(negedge core_clk); while (phase !== PH_Q3);
    @(posedge core_clk);
    prog_word <= w;
    pc_in <= pc;
    overflow_flag <= ov;
    zero_flag <= zf;
    @(posedge core_clk);
    prog_word <= w2;
    {n_wr, n_push, n_rd, n_dw, n_zs, n_idle, n_idx} = '0;
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk);
      n_idle += int'(idle_cycle === 1'b1);
      n_idx += int'(indexed_mode === 1'b1);
      n_zs += int'(zero_set === 1'b1);
      if (pc_wr === 1'b1) begin
        n_wr++;
        g_pc = pc_wr_data;
        check(phase, PH_Q4);
      end
      if (stack_push === 1'b1) begin
        n_push++;
        g_ret = return_stack_top;
        check(phase, PH_Q3);
      end
      if (dmem_rd === 1'b1) begin
        n_rd++;
        g_raddr = dmem_addr;
        check(phase, PH_Q2);
      end
      if (dmem_wr === 1'b1) begin
        n_dw++;
        g_addr = dmem_addr;
        check(phase, PH_Q4);
      end
    end
  endtask

  task automatic expect_out(input int wr, input logic [PC_W-1:0] pc, input int push,
      input logic [PC_W-1:0] ret, input int clr, input logic [DADDR_W-1:0] addr,
      input int idle, input int idx);
    check(n_wr, wr);
    if (wr > 0) check(g_pc, pc);
    check(n_push, push);
    if (push > 0) check(g_ret, ret);
    check(n_rd, clr);
    check(n_dw, clr);
    check(n_zs, clr);
    if (clr > 0) check(g_raddr, addr);
    if (clr > 0) check(g_addr, addr);
    if (clr > 0) check(dm.mem[addr], 8'h00);
    check(n_idle, idle * 4);
    check(n_idx, idx * 3);
  endtask

  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    run(16'he480, 16'hffff, 21'h001000, 1'b1, 1'b0);
    expect_out(1, 21'h000f02, 0, '0, 0, '0, 1, 0);
    run(16'he47f, 16'hffff, 21'h001000, 1'b0, 1'b1);
    expect_out(0, '0, 0, '0, 0, '0, 0, 0);
    run(16'he07f, 16'hffff, 21'h00abc0, 1'b0, 1'b1);
    expect_out(1, 21'h00acc0, 0, '0, 0, '0, 1, 0);
    run(16'he080, 16'hffff, 21'h00abc0, 1'b1, 1'b0);
    expect_out(0, '0, 0, '0, 0, '0, 0, 0);
    // Call with shadow save, then without
    run(16'hed5a, 16'hf9c3, 21'h000200, 1'b1, 1'b1);
    expect_out(1, 21'h1386b4, 1, 21'h000204, 0, '0, 1, 0);
    check(working_shadow, 8'h3c);
    check(flags_shadow, 8'h1f);
    check(bank_select_shadow, 4'h5);
    @(posedge core_clk);
    working_reg <= 8'hc3;
    flags_reg <= 8'h00;
    bank_select_reg <= 4'ha;
    run(16'hec01, 16'hf000, 21'h1ffff8, 1'b0, 1'b0);
    expect_out(1, 21'h000002, 1, 21'h1ffffc, 0, '0, 1, 0);
    check(working_shadow, 8'h3c);
    check(flags_shadow, 8'h1f);
    check(bank_select_shadow, 4'h5);
    check(dm.stk[1], 21'h1ffffc);
    @(posedge core_clk);
    bank_select_reg <= 4'h5;
    run(16'h6bab, 16'hffff, 21'h000100, 1'b0, 1'b0);
    expect_out(0, '0, 0, '0, 1, 12'h5ab, 0, 0);
    run(16'h6a90, 16'hffff, 21'h000100, 1'b0, 1'b0);
    expect_out(0, '0, 0, '0, 1, 12'hf90, 0, 0);
    run(16'h6a20, 16'hffff, 21'h000100, 1'b0, 1'b0);
    expect_out(0, '0, 0, '0, 1, 12'h020, 0, 0);
    @(posedge core_clk);
    ext_set_en <= 1'b1;
    run(16'h6a5f, 16'hffff, 21'h000100, 1'b0, 1'b0);
    expect_out(0, '0, 0, '0, 1, 12'h35f, 0, 1);
    run(16'h6a60, 16'hffff, 21'h000100, 1'b0, 1'b0);
    expect_out(0, '0, 0, '0, 1, 12'h060, 0, 0);
    run(16'h6b10, 16'hffff, 21'h000100, 1'b0, 1'b0);
    expect_out(0, '0, 0, '0, 1, 12'h510, 0, 0);
    print_verdict();
  end
endmodule
